// >>> verilog/tcp_pkg.sv
package tcp_pkg;
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int EXEC_MAX_MS = 20;
    localparam int EXEC_MAX_CYC = CLK_HZ / 1000 * EXEC_MAX_MS;
    localparam int PENALTY_MS = 5;
    localparam int PENALTY_CYC = CLK_HZ / 1000 * PENALTY_MS;

    // Address byte and command codes
    localparam logic [7:0] BUS_ID_RESET = 8'hc0;
    localparam int ADR_SEL_BIT = 1;
    localparam int ADR_RW_BIT = 0;
    localparam logic [7:0] CMD_FIRST = 8'h01;
    localparam logic [7:0] CMD_ILLEGAL_MIN = 8'h15;

    // Status byte layout
    localparam int ST_RDY = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_LINK = 2;
    localparam int ST_ERR_LSB = 5;
    localparam logic [2:0] ERR_OK = 3'h0;
    localparam logic [2:0] ERR_LOCKOUT = 3'h1;
    localparam logic [2:0] ERR_MALFORMED = 3'h2;
    localparam logic [2:0] ERR_PENALTY = 3'h3;
    localparam logic [2:0] ERR_AUTH = 3'h4;

    // Controller registers
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_DIV = 8'h08;
    localparam logic [7:0] DIV_RESET = 8'h04;
    localparam logic [2:0] OP_START = 3'h1;
    localparam logic [2:0] OP_WRITE = 3'h2;
    localparam logic [2:0] OP_READ_ACK = 3'h3;
    localparam logic [2:0] OP_READ_NACK = 3'h4;
    localparam logic [2:0] OP_STOP = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        TS_IDLE, TS_RX, TS_ACK, TS_TX, TS_RACK
    } tcp_twi_e;
    typedef enum logic [1:0] {M_CMD, M_OUT, M_STAT} tcp_mode_e;
endpackage

// >>> verilog/tcp_if.sv
`timescale 1ns/1ps
interface tcp_if;
    logic scl_o;
    logic scl_oe;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

    modport host_mp(output scl_o, scl_oe, sda_h_o, sda_h_oe,
                    input scl, sda);
    modport dev_mp(output sda_d_o, sda_d_oe, input scl, sda);
endinterface

// >>> verilog/tcp_sync.sv
`timescale 1ns/1ps
module tcp_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // Two-flop synchroniser, idles high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '1;
            q <= '1;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // tcp_sync

// >>> verilog/tcp_dev.sv
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// RQ1 - Command write: address bits 1,0 clear
// RQ2 - Code, length, then length operands
// RQ3 - Legal code acked, execution starts
// RQ4 - Busy through execution, 20 ms cap
// RQ5 - Code 0x15 up: penalty delay
// RQ6 - Legal codes 0x01 to 0x14
// RQ7 - Output read: length then data
// RQ8 - Output rereadable until new command
// RQ9 - Old output kept while command arrives; operand bytes overwrite the shared output buffer here
// RQ10 - No output: ready clear, length zero
// RQ11 - Status read returns status byte
// RQ12 - Status readable at any time
// RQ13 - Bit 0 output ready
// RQ14 - Bit 1 busy blocks commands
// RQ15 - Bit 2 latches challenge reply success
// RQ16 - Bits 5-7 error, 3-4 zero
// RQ17 - Code 1 lockout, busy until reset
// RQ18 - Code 2 malformed request
// RQ19 - Code 3 penalty wait, busy set
// RQ20 - Code 4 authentication failure
// RQ21 - Master polls status before output
// RQ22 - Status write not acknowledged
// RQ23 - Address upper six bits match id
// RQ24 - Command address refused while busy
module tcp_dev #(
    parameter int EXEC_MAX = tcp_pkg::EXEC_MAX_CYC,
    parameter int PENALTY = tcp_pkg::PENALTY_CYC,
    parameter logic [7:0] BUS_ID = tcp_pkg::BUS_ID_RESET
) (
    input wire logic aclk,
    input wire logic aresetn,
    tcp_if.dev_mp link,
    output logic cmd_start,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_len,
    input wire logic buf_we,
    input wire logic [7:0] buf_addr,
    input wire logic [7:0] buf_wdata,
    output logic [7:0] buf_rdata,
    input wire logic done,
    input wire logic [7:0] done_len,
    input wire logic [2:0] done_err,
    input wire logic done_link,
    input wire logic lockout_req,
    output logic [7:0] status
);
    tcp_pkg::tcp_twi_e st, next_st;
    tcp_pkg::tcp_mode_e mode, next_mode;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh;
    logic sda_oe, next_sda_oe;
    logic first, next_first;
    logic [8:0] wbyte, next_wbyte;
    logic [7:0] rbyte, next_rbyte;
    logic [7:0] next_code, next_len;
    logic busy, next_busy;
    logic pen, next_pen;
    logic locked, next_locked;
    logic out_ready, next_out_ready;
    logic link_ok, next_link_ok;
    logic [2:0] err, next_err;
    logic [7:0] out_len, next_out_len;
    logic [31:0] tmr, next_tmr;
    logic next_cmd_start;
    logic [7:0] next_status;
    logic scl_s, sda_s, scl_p, sda_p;
    logic scl_rise, scl_fall, is_start, is_stop;
    logic ack, exec_go, pen_go, tw_we;
    logic [7:0] tw_addr, txb;
    logic [7:0] mem [256];

    tcp_sync #(.W(2)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({link.scl, link.sda}),
        .q({scl_s, sda_s})
    );

    // Bus edges, start and stop
    assign scl_rise = scl_s & ~scl_p;
    assign scl_fall = ~scl_s & scl_p;
    assign is_start = scl_s & scl_p & sda_p & ~sda_s;
    assign is_stop = scl_s & scl_p & ~sda_p & sda_s;
    assign link.sda_d_o = 1'b0;
    assign link.sda_d_oe = sda_oe;

    // Next byte to send
    always_comb begin
        if (mode == tcp_pkg::M_STAT) begin
            txb = status; // RQ11 RQ12
        end else if (rbyte == 8'h00) begin
            txb = out_ready ? out_len : 8'h00; // RQ7 RQ10
        end else begin
            txb = mem[8'(rbyte - 8'h01)]; // RQ8
        end
    end

    // Bus slave and command state
    always_comb begin
        next_st = st;
        next_mode = mode;
        next_cnt = cnt;
        next_sh = sh;
        next_sda_oe = sda_oe;
        next_first = first;
        next_wbyte = wbyte;
        next_rbyte = rbyte;
        next_code = cmd_code;
        next_len = cmd_len;
        next_busy = busy;
        next_pen = pen;
        next_locked = locked;
        next_out_ready = out_ready;
        next_link_ok = link_ok;
        next_err = err;
        next_out_len = out_len;
        next_tmr = tmr;
        next_cmd_start = 1'b0;
        ack = 1'b0;
        exec_go = 1'b0;
        pen_go = 1'b0;
        tw_we = 1'b0;
        tw_addr = 8'(wbyte - 9'h002);
        case (st)
            tcp_pkg::TS_IDLE: begin
            end
            tcp_pkg::TS_RX: begin
                if (scl_rise) begin
                    next_sh = {sh[6:0], sda_s};
                    next_cnt = cnt + 4'h1;
                end else if (scl_fall && cnt == 4'h8) begin
                    if (first) begin
                        next_wbyte = 9'h000;
                        next_rbyte = 8'h00;
                        if (sh[7:2] == BUS_ID[7:2]) begin // RQ23
                            if (!sh[tcp_pkg::ADR_SEL_BIT]) begin
                                ack = ~busy; // RQ14 RQ24 RQ1
                            end else begin
                                ack = sh[tcp_pkg::ADR_RW_BIT]; // RQ22
                            end
                        end
                        if (sh[tcp_pkg::ADR_SEL_BIT]) begin
                            next_mode = tcp_pkg::M_STAT;
                        end else if (sh[tcp_pkg::ADR_RW_BIT]) begin
                            next_mode = tcp_pkg::M_OUT; // RQ7
                        end else begin
                            next_mode = tcp_pkg::M_CMD;
                        end
                    end else if (!busy) begin
                        next_wbyte = wbyte + 9'h001;
                        if (wbyte == 9'h000) begin
                            if (sh >= tcp_pkg::CMD_FIRST &&
                                sh < tcp_pkg::CMD_ILLEGAL_MIN) begin
                                ack = 1'b1; // RQ3 RQ6
                                next_code = sh;
                            end else begin
                                pen_go = 1'b1; // RQ5
                            end
                        end else if (wbyte == 9'h001) begin
                            ack = 1'b1;
                            next_len = sh; // RQ2
                            exec_go = (sh == 8'h00);
                        end else begin
                            ack = 1'b1;
                            tw_we = 1'b1; // RQ9
                            exec_go = (wbyte == {1'b0, cmd_len} + 9'h001);
                        end
                    end
                    next_first = 1'b0;
                    next_sda_oe = ack;
                    next_st = ack ? tcp_pkg::TS_ACK : tcp_pkg::TS_IDLE;
                end
            end
            tcp_pkg::TS_ACK, tcp_pkg::TS_RACK: begin
                if (st == tcp_pkg::TS_RACK && scl_rise && sda_s) begin
                    next_st = tcp_pkg::TS_IDLE;
                end else if (scl_fall && mode == tcp_pkg::M_CMD) begin
                    next_sda_oe = 1'b0;
                    next_cnt = 4'h0;
                    next_st = tcp_pkg::TS_RX;
                end else if (scl_fall) begin
                    next_sda_oe = ~txb[7];
                    next_sh = {txb[6:0], 1'b0};
                    next_cnt = 4'h1;
                    next_rbyte = rbyte + 8'h01;
                    next_st = tcp_pkg::TS_TX;
                end
            end
            tcp_pkg::TS_TX: begin
                if (scl_fall && cnt == 4'h8) begin
                    next_sda_oe = 1'b0;
                    next_st = tcp_pkg::TS_RACK;
                end else if (scl_fall) begin
                    next_sda_oe = ~sh[7];
                    next_sh = {sh[6:0], 1'b0};
                    next_cnt = cnt + 4'h1;
                end
            end
            default: next_st = tcp_pkg::TS_IDLE;
        endcase
        if (is_start) begin
            next_st = tcp_pkg::TS_RX;
            next_cnt = 4'h0;
            next_first = 1'b1;
            next_sda_oe = 1'b0;
        end else if (is_stop) begin
            next_st = tcp_pkg::TS_IDLE;
            next_sda_oe = 1'b0;
        end
        // Execution and penalty timing
        if (exec_go) begin
            next_busy = 1'b1; // RQ4
            next_out_ready = 1'b0; // RQ9
            next_err = tcp_pkg::ERR_OK;
            next_tmr = 32'h0;
            next_cmd_start = 1'b1; // RQ3
        end else if (pen_go) begin
            next_busy = 1'b1;
            next_pen = 1'b1;
            next_err = tcp_pkg::ERR_PENALTY; // RQ19
            next_tmr = 32'h0;
        end else if (busy && !locked) begin
            next_tmr = tmr + 32'h1;
            if (pen) begin
                if (tmr == 32'(PENALTY - 1)) begin
                    next_busy = 1'b0; // RQ5
                    next_pen = 1'b0;
                    next_err = tcp_pkg::ERR_OK;
                end
            end else if (done) begin
                next_busy = 1'b0;
                next_out_len = done_len;
                next_out_ready = (done_len != 8'h00); // RQ13 RQ10
                next_err = done_err; // RQ18 RQ20
                next_link_ok = link_ok | done_link; // RQ15
            end else if (tmr == 32'(EXEC_MAX - 1)) begin
                next_busy = 1'b0; // RQ4
                next_out_len = 8'h00;
                next_out_ready = 1'b0;
            end
        end
        if (lockout_req) begin
            next_locked = 1'b1; // RQ17
            next_busy = 1'b1;
            next_err = tcp_pkg::ERR_LOCKOUT;
        end
        next_status = 8'h00; // RQ16
        next_status[tcp_pkg::ST_RDY] = next_out_ready;
        next_status[tcp_pkg::ST_BUSY] = next_busy; // RQ14
        next_status[tcp_pkg::ST_LINK] = next_link_ok;
        next_status[tcp_pkg::ST_ERR_LSB +: 3] = next_err;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= tcp_pkg::TS_IDLE;
            mode <= tcp_pkg::M_STAT;
            cnt <= 4'h0;
            sh <= 8'h00;
            sda_oe <= 1'b0;
            first <= 1'b0;
            wbyte <= 9'h000;
            rbyte <= 8'h00;
            cmd_code <= 8'h00;
            cmd_len <= 8'h00;
            busy <= 1'b0;
            pen <= 1'b0;
            locked <= 1'b0;
            out_ready <= 1'b0;
            link_ok <= 1'b0;
            err <= tcp_pkg::ERR_OK;
            out_len <= 8'h00;
            tmr <= 32'h0;
            cmd_start <= 1'b0;
            status <= 8'h00;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            st <= next_st;
            mode <= next_mode;
            cnt <= next_cnt;
            sh <= next_sh;
            sda_oe <= next_sda_oe;
            first <= next_first;
            wbyte <= next_wbyte;
            rbyte <= next_rbyte;
            cmd_code <= next_code;
            cmd_len <= next_len;
            busy <= next_busy;
            pen <= next_pen;
            locked <= next_locked;
            out_ready <= next_out_ready;
            link_ok <= next_link_ok;
            err <= next_err;
            out_len <= next_out_len;
            tmr <= next_tmr;
            cmd_start <= next_cmd_start;
            status <= next_status;
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    // Shared buffer
    always_ff @(posedge aclk) begin
        if (tw_we) begin
            mem[tw_addr] <= sh; // RQ9
        end else if (buf_we) begin
            mem[buf_addr] <= buf_wdata;
        end
        buf_rdata <= mem[buf_addr];
    end
endmodule // tcp_dev

// >>> verilog/tcp_host.sv
`timescale 1ns/1ps
module tcp_host (
    input wire logic aclk,
    input wire logic aresetn,
    tcp_if.host_mp link,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic aw_full, next_aw_full, w_full, next_w_full;
    logic [7:0] awa, next_awa;
    logic [31:0] wd, next_wd;
    logic [3:0] ws, next_ws;
    logic next_awready, next_wready, next_arready;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [7:0] div, next_div, divcnt, next_divcnt;
    logic [2:0] op, next_op;
    logic busy, next_busy, nack, next_nack;
    logic [1:0] ph, next_ph;
    logic [3:0] bitn, next_bitn;
    logic [7:0] sh, next_sh, rx, next_rx;
    logic scl_oe, next_scl_oe, sda_oe, next_sda_oe;
    logic sda_s, tick, wr;

    tcp_sync #(.W(1)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(link.sda),
        .q(sda_s)
    );

    assign link.scl_o = 1'b0;
    assign link.scl_oe = scl_oe;
    assign link.sda_h_o = 1'b0;
    assign link.sda_h_oe = sda_oe;
    assign tick = busy && (divcnt == 8'(div - 8'h01));
    assign wr = (op == tcp_pkg::OP_WRITE);

    // Register slave and bus bit engine
    always_comb begin
        next_aw_full = aw_full | (s_axi_awvalid & s_axi_awready);
        next_w_full = w_full | (s_axi_wvalid & s_axi_wready);
        next_awa = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr[7:0] : awa;
        next_wd = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd;
        next_ws = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : ws;
        next_bvalid = s_axi_bvalid & ~s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid & ~s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_div = div;
        next_divcnt = tick ? 8'h00 : divcnt + 8'h01;
        next_op = op;
        next_busy = busy;
        next_nack = nack;
        next_ph = ph;
        next_bitn = bitn;
        next_sh = sh;
        next_rx = rx;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        if (tick) begin
            next_ph = ph + 2'h1;
            case (op)
                tcp_pkg::OP_START: begin
                    next_scl_oe = (ph == 2'h0) || (ph == 2'h3);
                    next_sda_oe = (ph >= 2'h2);
                    if (ph == 2'h3) begin
                        next_op = tcp_pkg::OP_WRITE; // RQ1 RQ11
                    end
                end
                tcp_pkg::OP_STOP: begin
                    next_scl_oe = (ph == 2'h0);
                    next_sda_oe = (ph < 2'h2);
                    next_busy = (ph != 2'h3);
                end
                default: begin
                    if (ph == 2'h0) begin
                        next_scl_oe = 1'b1;
                        if (bitn < 4'h8) begin
                            next_sda_oe = wr & ~sh[7]; // RQ2
                        end else begin
                            next_sda_oe = (op == tcp_pkg::OP_READ_ACK);
                        end
                    end else if (ph == 2'h1) begin
                        next_scl_oe = 1'b0;
                    end else if (ph == 2'h2) begin
                        if (bitn < 4'h8) begin
                            next_rx = {rx[6:0], sda_s};
                            next_sh = {sh[6:0], 1'b0};
                        end else if (wr) begin
                            next_nack = sda_s;
                        end
                    end else begin
                        next_scl_oe = 1'b1;
                        next_bitn = bitn + 4'h1;
                        next_busy = (bitn != 4'h8);
                    end
                end
            endcase
        end
        // Write once both halves held
        if (aw_full && w_full && !s_axi_bvalid) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = tcp_pkg::RESP_OKAY;
            if (awa == tcp_pkg::REG_CTRL) begin
                if (!busy && wd[2:0] >= tcp_pkg::OP_START &&
                    wd[2:0] <= tcp_pkg::OP_STOP) begin
                    next_op = wd[2:0]; // RQ21
                    next_sh = wd[15:8];
                    next_busy = 1'b1;
                    next_ph = 2'h0;
                    next_bitn = 4'h0;
                    next_divcnt = 8'h00;
                    next_nack = 1'b0;
                end
            end else if (awa == tcp_pkg::REG_DIV) begin
                if (ws[0] && wd[7:0] != 8'h00) begin
                    next_div = wd[7:0];
                end
            end else if (awa != tcp_pkg::REG_STAT) begin
                next_bresp = tcp_pkg::RESP_SLVERR;
            end
        end
        // Read answer
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = tcp_pkg::RESP_OKAY;
            case (s_axi_araddr[7:0])
                tcp_pkg::REG_STAT: next_rdata = {16'h0, rx, 6'h0, nack, busy};
                tcp_pkg::REG_DIV: next_rdata = {24'h0, div};
                tcp_pkg::REG_CTRL: next_rdata = {16'h0, sh, 5'h0, op};
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = tcp_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_awready = ~next_aw_full;
        next_wready = ~next_w_full;
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awa <= 8'h00;
            wd <= 32'h0;
            ws <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
            div <= tcp_pkg::DIV_RESET;
            divcnt <= 8'h00;
            op <= 3'h0;
            busy <= 1'b0;
            nack <= 1'b0;
            ph <= 2'h0;
            bitn <= 4'h0;
            sh <= 8'h00;
            rx <= 8'h00;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            awa <= next_awa;
            wd <= next_wd;
            ws <= next_ws;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            div <= next_div;
            divcnt <= next_divcnt;
            op <= next_op;
            busy <= next_busy;
            nack <= next_nack;
            ph <= next_ph;
            bitn <= next_bitn;
            sh <= next_sh;
            rx <= next_rx;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
        end
    end
endmodule // tcp_host

// >>> bench/tcp_props.sv
`timescale 1ns/1ps
module tcp_props (
    input logic aclk,
    input logic aresetn,
    input logic scl_o,
    input logic scl_oe,
    input logic sda_h_o,
    input logic sda_h_oe,
    input logic sda_d_o,
    input logic sda_d_oe,
    input logic scl,
    input logic sda
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Open drain, pull low only
    a_host_scl_od: assert property (scl_oe |-> !scl_o)
        else $error("host drives scl high");
    a_host_sda_od: assert property (sda_h_oe |-> !sda_h_o)
        else $error("host drives sda high");
    a_dev_sda_od: assert property (sda_d_oe |-> !sda_d_o)
        else $error("device drives sda high");
    // Device moves sda only while scl low
    a_dev_edge_low: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("sda moved, scl high");
    a_dev_release: assert property (sda_d_oe |-> ##[1:200] !sda_d_oe)
        else $error("sda held too long");
    a_no_contention: assert property (scl |-> !(sda_h_oe && sda_d_oe))
        else $error("both ends drive sda");
    // Scl phases last at least four cycles
    a_scl_high_min: assert property ($rose(scl) |=> scl [*3])
        else $error("short scl high");
    a_scl_low_min: assert property ($fell(scl) |=> !scl [*3])
        else $error("short scl low");
    a_start_by_host: assert property ($fell(sda) && scl |-> sda_h_oe)
        else $error("start not by host");
    c_start: cover property ($fell(sda) && scl);
    c_dev_ack: cover property (scl && sda_d_oe);
    c_stop: cover property ($rose(sda) && scl);
endmodule // tcp_props

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic aclk = 0, aresetn = 0, buf_we = 0, done = 0, lockout_req = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, fin = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, cmd_start;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] cmd_len;
    logic [2:0] de = 0;
    int err_count = 0, cmp_count = 0;
    tcp_if link();
    tcp_dev #(.EXEC_MAX(4000), .PENALTY(2000)) u_tcp_dev(.aclk, .aresetn,
        .link, .cmd_start, .cmd_code(), .cmd_len, .buf_we,
        .buf_addr(8'h00), .buf_wdata(8'h5a), .buf_rdata(), .done,
        .done_len(cmd_len), .done_err(de), .done_link(1'b1),
        .lockout_req, .status());
    tcp_host u_tcp_host(.*);
    tcp_props u_tcp_props(.aclk, .aresetn, .scl_o(link.scl_o),
        .scl_oe(link.scl_oe), .sda_h_o(link.sda_h_o),
        .sda_h_oe(link.sda_h_oe), .sda_d_o(link.sda_d_o),
        .sda_d_oe(link.sda_d_oe), .scl(link.scl), .sda(link.sda));
    // Clock and watchdog
    initial forever #20 aclk = ~aclk;
    initial begin
        #2_000_000;
        err_count++;
        summarize;
    end
    // Command engine model
    initial forever begin
        @(negedge aclk);
        if (cmd_start === 1'b1) begin
            repeat (1000) @(posedge aclk);
            buf_we <= 1;
            done <= 1;
            @(posedge aclk);
            buf_we <= 0;
            done <= 0;
            fin <= 1;
        end
    end
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        cmp_count++;
        if (g !== e) begin
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
            err_count++;
        end
    endtask
    task automatic rst;
        aresetn <= 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
    endtask
    // One AXI4-Lite write or read, q and r hold the answer
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic t, w, z;
        @(posedge aclk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_araddr <= {24'h0, a};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do begin
            @(negedge aclk);
            t = wr ? s_axi_awready && s_axi_awvalid
                   : s_axi_arready && s_axi_arvalid;
            w = s_axi_wready && s_axi_wvalid;
            z = wr ? s_axi_bvalid : s_axi_rvalid;
            q = s_axi_rdata;
            r = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (t) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (w) s_axi_wvalid <= 0;
        end while (z !== 1'b1);
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask
    // Controller operation, poll until idle
    task automatic tw(input logic [2:0] op, input logic [7:0] b);
        axi(1, tcp_pkg::REG_CTRL, {16'h0, b, 5'h0, op});
        do axi(0, tcp_pkg::REG_STAT, 0);
        while (q[0] !== 1'b0);
    endtask
    task automatic adr(input logic [7:0] a, input logic n);
        tw(tcp_pkg::OP_START, a);
        chk(q[1], n);
    endtask
    task automatic wb(input logic [7:0] b, input logic n);
        tw(tcp_pkg::OP_WRITE, b);
        chk(q[1], n);
    endtask
    task automatic rdb(input logic [2:0] op, input logic [7:0] e);
        tw(op, 8'h00);
        chk(q[15:8], e);
    endtask
    task automatic sts(input logic [7:0] m, e);
        adr(8'hc3, 0);
        tw(tcp_pkg::OP_READ_NACK, 8'h00);
        chk(q[15:8] & m, e);
        tw(tcp_pkg::OP_STOP, 8'h00);
    endtask
    // Test sequence
    initial begin
        rst;
        axi(0, tcp_pkg::REG_DIV, 0);
        chk(q, {24'h0, tcp_pkg::DIV_RESET});
        axi(0, 8'h0c, 0);
        chk(r, tcp_pkg::RESP_SLVERR);
        $display("register test done");
        sts(8'hff, 8'h00);
        adr(8'h83, 1);
        tw(tcp_pkg::OP_STOP, 0);
        adr(8'hc2, 1);
        tw(tcp_pkg::OP_STOP, 0);
        fin <= 0;
        adr(8'hc0, 0);
        wb(8'h0c, 0);
        wb(8'h01, 0);
        wb(8'ha5, 0);
        tw(tcp_pkg::OP_STOP, 0);
        adr(8'hc0, 1);
        tw(tcp_pkg::OP_STOP, 0);
        sts(8'hff, 8'h02);
        wait (fin);
        sts(8'hff, 8'h05);
        repeat (2) begin
            adr(8'hc1, 0);
            rdb(tcp_pkg::OP_READ_ACK, 8'h01);
            rdb(tcp_pkg::OP_READ_NACK, 8'h5a);
            tw(tcp_pkg::OP_STOP, 0);
        end
        $display("command test done");
        fin <= 0;
        de <= tcp_pkg::ERR_MALFORMED;
        adr(8'hc0, 0);
        wb(8'h14, 0);
        wb(8'h00, 0);
        tw(tcp_pkg::OP_STOP, 0);
        wait (fin);
        sts(8'hff, 8'h44);
        adr(8'hc1, 0);
        rdb(tcp_pkg::OP_READ_NACK, 8'h00);
        tw(tcp_pkg::OP_STOP, 0);
        adr(8'hc0, 0);
        wb(8'h15, 1);
        tw(tcp_pkg::OP_STOP, 0);
        sts(8'he6, 8'h66);
        repeat (2000) @(posedge aclk);
        sts(8'he6, 8'h04);
        $display("penalty test done");
        lockout_req <= 1;
        @(posedge aclk);
        lockout_req <= 0;
        sts(8'he6, 8'h26);
        rst;
        sts(8'hff, 8'h00);
        $display("lockout test done");
        summarize;
    end
endmodule // testbench
